/* File: core/ccvr_defs.vh */
// Purpose: Constants for the charge current and voltage register bank.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Values in mA, mV or percent of the internal regulator rail.
`ifndef CCVR_DEFS_VH
`define CCVR_DEFS_VH

// Serial target address and register offsets
`define CCVR_TARGET_ADDR 7'h6B
`define CCVR_CHG_CUR_OFS 8'h02
`define CCVR_PRE_TERM_OFS 8'h03
`define CCVR_CHG_VOLT_OFS 8'h04

// Reset values
`define CCVR_CHG_CUR_RST 8'h60
`define CCVR_PRE_TERM_RST 8'h11
`define CCVR_CHG_VOLT_RST 8'hB2

// Field positions
`define CCVR_FAST_CHARGE_CURRENT_CODE_MSB 7
`define CCVR_FAST_CHARGE_CURRENT_CODE_LSB 2
`define CCVR_COLD_SEL_BIT 1
`define CCVR_FORCE_BIT 0
`define CCVR_IPRE_MSB 7
`define CCVR_IPRE_LSB 4
`define CCVR_TERMINATION_CURRENT_CODE_MSB 2
`define CCVR_TERMINATION_CURRENT_CODE_LSB 0
`define CCVR_CHARGE_VOLTAGE_CODE_MSB 7
`define CCVR_CHARGE_VOLTAGE_CODE_LSB 2
`define CCVR_EXIT_SEL_BIT 1
`define CCVR_RECHG_SEL_BIT 0

// Decode offsets and choices
`define CCVR_FAST_CHARGE_CURRENT_CODE_BASE_MA 13'h200
`define CCVR_FORCE_DIV 13'h005
`define CCVR_STEP128_MA 12'h080
`define CCVR_CHARGE_VOLTAGE_CODE_BASE_MV 13'hDB0
`define CCVR_EXIT_LOW_MV 12'hAF0
`define CCVR_EXIT_HIGH_MV 12'hBB8
`define CCVR_RECHG_LOW_MV 9'h064
`define CCVR_RECHG_HIGH_MV 9'h12C
`define CCVR_COLD_LOW_PCT 7'h4C
`define CCVR_COLD_HIGH_PCT 7'h4F

`endif

/* File: core/ccvr_sync.v */
// Purpose: Two-flop synchroniser for one bus pin.
// Assumes: Pin is asynchronous to clk.
// Notes: First flop is read only by the second.
module ccvr_sync #(
   parameter RESET_VAL = 1'b1
) (
   input wire clk,
   input wire nrst,
   input wire pin_i,
   output wire sync_o
);
   reg meta_q;
   reg sync_q;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

/* File: core/ccvr_top.v */
// Purpose: Serial target with charge current, pre-charge/termination and
//    charge voltage registers, plus decoded targets for the charger loops.
// Assumes: Bus pins asynchronous to clk; clk well above 8x the bus clock.
// Notes: Pointer auto-increments; unmapped offsets read 0x00, writes dropped.
`include "ccvr_defs.vh"

module ccvr_top (
   input wire clk,
   input wire nrst,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output reg sda_oe,
   output reg [12:0] fast_charge_target_ma,
   output reg [11:0] precharge_target_ma,
   output reg [11:0] termination_target_ma,
   output reg [12:0] charge_voltage_target_mv,
   output reg [11:0] precharge_exit_mv,
   output reg [8:0] recharge_offset_mv,
   output reg [6:0] boost_cold_threshold_pct
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_ACK = 3'h2;
   localparam [2:0] ST_PTR = 3'h3;
   localparam [2:0] ST_WDATA = 3'h4;
   localparam [2:0] ST_RDATA = 3'h5;
   localparam [2:0] ST_RACK = 3'h6;

   wire scl_s;
   wire sda_s;
   reg scl_q;
   reg sda_q;
   reg [2:0] state_q;
   reg [2:0] next_q;
   reg [3:0] cnt_q;
   reg [7:0] rx_q;
   reg [7:0] tx_q;
   reg [7:0] ptr_q;
   reg nack_q;
   reg [7:0] chg_cur_q;
   reg [7:0] pre_term_q;
   reg [7:0] chg_volt_q;
   reg [7:0] rd_data;
   reg wr_en;

   ccvr_sync #(.RESET_VAL(1'b1)) u_scl_sync (
      .clk(clk),
      .nrst(nrst),
      .pin_i(scl_i),
      .sync_o(scl_s)
   );

   ccvr_sync #(.RESET_VAL(1'b1)) u_sda_sync (
      .clk(clk),
      .nrst(nrst),
      .pin_i(sda_i),
      .sync_o(sda_s)
   );

   // Open-drain: only ever pulls low
   assign sda_o = 1'b0;

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
   wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

   // Read mux over the pointer
   always @* begin
      case (ptr_q)
         `CCVR_CHG_CUR_OFS: rd_data = chg_cur_q;
         `CCVR_PRE_TERM_OFS: rd_data = pre_term_q;
         `CCVR_CHG_VOLT_OFS: rd_data = chg_volt_q;
         default: rd_data = 8'h00;
      endcase
   end

   // Write strobe at the end of a data byte
   always @* begin
      wr_en = (state_q == ST_WDATA) && scl_fall && (cnt_q == 4'h8);
   end

   // Serial protocol engine
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_q <= ST_IDLE;
         next_q <= ST_IDLE;
         cnt_q <= 4'h0;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         nack_q <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         if (bus_start) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state_q)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  if (scl_rise) begin
                     rx_q <= {rx_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     if (state_q == ST_ADDR) begin
                        if (rx_q[7:1] == `CCVR_TARGET_ADDR) begin
                           sda_oe <= 1'b1;
                           state_q <= ST_ACK;
                           next_q <= rx_q[0] ? ST_RDATA : ST_PTR;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else begin
                        sda_oe <= 1'b1;
                        state_q <= ST_ACK;
                        next_q <= ST_WDATA;
                        if (state_q == ST_PTR) begin
                           ptr_q <= rx_q;
                        end else begin
                           ptr_q <= ptr_q + 8'h01;
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     state_q <= next_q;
                     cnt_q <= 4'h0;
                     if (next_q == ST_RDATA) begin
                        tx_q <= {rd_data[6:0], 1'b0};
                        sda_oe <= ~rd_data[7];
                        cnt_q <= 4'h1;
                        ptr_q <= ptr_q + 8'h01;
                     end else begin
                        sda_oe <= 1'b0;
                     end
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (cnt_q == 4'h8) begin
                        sda_oe <= 1'b0;
                        state_q <= ST_RACK;
                     end else begin
                        sda_oe <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_s;
                  end else if (scl_fall) begin
                     if (nack_q) begin
                        state_q <= ST_IDLE;
                     end else begin
                        state_q <= ST_RDATA;
                        tx_q <= {rd_data[6:0], 1'b0};
                        sda_oe <= ~rd_data[7];
                        cnt_q <= 4'h1;
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // Per-register write strobes; writes to other offsets fall away here
   wire wr_chg_cur = wr_en && (ptr_q == `CCVR_CHG_CUR_OFS);
   wire wr_pre_term = wr_en && (ptr_q == `CCVR_PRE_TERM_OFS);
   wire wr_chg_volt = wr_en && (ptr_q == `CCVR_CHG_VOLT_OFS);

   // Register bank
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chg_cur_q <= `CCVR_CHG_CUR_RST;
      end else if (wr_chg_cur) begin
         chg_cur_q <= rx_q;
      end
   end

   // Reserved bit 3 is stored but drives nothing
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_term_q <= `CCVR_PRE_TERM_RST;
      end else if (wr_pre_term) begin
         pre_term_q <= rx_q;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chg_volt_q <= `CCVR_CHG_VOLT_RST;
      end else if (wr_chg_volt) begin
         chg_volt_q <= rx_q;
      end
   end

   // Field decode
   wire [5:0] fast_charge_current_code = chg_cur_q[`CCVR_FAST_CHARGE_CURRENT_CODE_MSB:`CCVR_FAST_CHARGE_CURRENT_CODE_LSB];
   wire reduced_current_force = chg_cur_q[`CCVR_FORCE_BIT];
   wire cold_threshold_sel = chg_cur_q[`CCVR_COLD_SEL_BIT];
   wire [3:0] precharge_current_code = pre_term_q[`CCVR_IPRE_MSB:`CCVR_IPRE_LSB];
   wire [2:0] termination_current_code = pre_term_q[`CCVR_TERMINATION_CURRENT_CODE_MSB:`CCVR_TERMINATION_CURRENT_CODE_LSB];
   wire [5:0] charge_voltage_code = chg_volt_q[`CCVR_CHARGE_VOLTAGE_CODE_MSB:`CCVR_CHARGE_VOLTAGE_CODE_LSB];
   wire precharge_exit_threshold_sel = chg_volt_q[`CCVR_EXIT_SEL_BIT];
   wire recharge_offset_sel = chg_volt_q[`CCVR_RECHG_SEL_BIT];

   wire [12:0] fast_charge_current_code_full = `CCVR_FAST_CHARGE_CURRENT_CODE_BASE_MA + {1'b0, fast_charge_current_code, 6'h00};
   wire [11:0] ipre_full = (precharge_current_code < 4'h2) ? `CCVR_STEP128_MA :
                           {1'b0, precharge_current_code, 7'h00} + `CCVR_STEP128_MA;
   wire [11:0] termination_current_code_full = `CCVR_STEP128_MA + {2'b00, termination_current_code, 7'h00};
   wire [12:0] charge_voltage_code_full = `CCVR_CHARGE_VOLTAGE_CODE_BASE_MV + {3'b000, charge_voltage_code, 4'h0};

   // Registered current targets; the force bit scales both charge phases
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fast_charge_target_ma <= 13'h0000;
         precharge_target_ma <= 12'h000;
      end else if (reduced_current_force) begin
         fast_charge_target_ma <= fast_charge_current_code_full / `CCVR_FORCE_DIV;
         precharge_target_ma <= {1'b0, ipre_full[11:1]};
      end else begin
         fast_charge_target_ma <= fast_charge_current_code_full;
         precharge_target_ma <= ipre_full;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         termination_target_ma <= 12'h000;
      end else begin
         termination_target_ma <= termination_current_code_full;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         charge_voltage_target_mv <= 13'h0000;
      end else begin
         charge_voltage_target_mv <= charge_voltage_code_full;
      end
   end

   // Registered threshold selections
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         precharge_exit_mv <= 12'h000;
      end else begin
         precharge_exit_mv <= precharge_exit_threshold_sel ?
                              `CCVR_EXIT_HIGH_MV : `CCVR_EXIT_LOW_MV;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         recharge_offset_mv <= 9'h000;
      end else begin
         recharge_offset_mv <= recharge_offset_sel ?
                               `CCVR_RECHG_HIGH_MV : `CCVR_RECHG_LOW_MV;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         boost_cold_threshold_pct <= 7'h00;
      end else begin
         boost_cold_threshold_pct <= cold_threshold_sel ?
                                     `CCVR_COLD_HIGH_PCT : `CCVR_COLD_LOW_PCT;
      end
   end
endmodule

/* File: sim/ccvr_checker.sv */
// Purpose: Port assertions for the charge register bank.
// Assumes: Decoded outputs are valid from the second edge after reset.
// Notes: Field checks hold for any contents the host may write.
module ccvr_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_oe,
   input wire logic [12:0] fast_charge_target_ma,
   input wire logic [11:0] precharge_target_ma,
   input wire logic [11:0] termination_target_ma,
   input wire logic [12:0] charge_voltage_target_mv,
   input wire logic [11:0] precharge_exit_mv,
   input wire logic [8:0] recharge_offset_mv,
   input wire logic [6:0] boost_cold_threshold_pct
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_rst_cur;
      $rose(nrst) |=> fast_charge_target_ma == 13'h800 && precharge_target_ma == 12'h080
         && termination_target_ma == 12'h100;
   endproperty
   a_rst_cur: assert property (p_rst_cur) else $error("Reset currents wrong");
   property p_rst_cfg;
      $rose(nrst) |=> charge_voltage_target_mv == 13'h1070 && precharge_exit_mv == 12'hBB8
         && recharge_offset_mv == 9'h064 && boost_cold_threshold_pct == 7'h4C;
   endproperty
   a_rst_cfg: assert property (p_rst_cfg) else $error("Reset settings wrong");
   property p_cold;
      $past(nrst) |-> boost_cold_threshold_pct inside {7'h4C, 7'h4F};
   endproperty
   a_cold: assert property (p_cold) else $error("Cold threshold bad");
   property p_sel;
      $past(nrst) |-> precharge_exit_mv inside {12'hAF0, 12'hBB8}
         && recharge_offset_mv inside {9'h064, 9'h12C};
   endproperty
   a_sel: assert property (p_sel) else $error("Threshold select bad");
   property p_term;
      $past(nrst) |-> termination_target_ma[6:0] == 7'h00
         && termination_target_ma inside {[12'h080:12'h400]};
   endproperty
   a_term: assert property (p_term) else $error("Termination current bad");
   property p_volt;
      $past(nrst) |-> charge_voltage_target_mv[3:0] == 4'h0
         && charge_voltage_target_mv inside {[13'hDB0:13'h11A0]};
   endproperty
   a_volt: assert property (p_volt) else $error("Charge voltage bad");
   property p_pre;
      $past(nrst) |-> precharge_target_ma[5:0] == 6'h00
         && precharge_target_ma inside {[12'h040:12'h800]};
   endproperty
   a_pre: assert property (p_pre) else $error("Pre-charge current bad");
   // Data may only move while the clock line is low
   property p_oe;
      $changed(sda_oe) |-> !scl_i;
   endproperty
   a_oe: assert property (p_oe) else $error("Data moved with clock high");
   c_ack: cover property ($rose(sda_oe));
   c_cold: cover property (boost_cold_threshold_pct == 7'h4F);
   c_exit: cover property (precharge_exit_mv == 12'hAF0);
endmodule
bind ccvr_top ccvr_checker u_chk (.clk, .nrst, .scl_i, .sda_oe, .fast_charge_target_ma,
   .precharge_target_ma, .termination_target_ma, .charge_voltage_target_mv,
   .precharge_exit_mv, .recharge_offset_mv, .boost_cold_threshold_pct);

/* File: sim/ccvr_host.sv */
// Purpose: Serial bus host driving the register bank.
// Assumes: Pull-up on the data line; each clock phase of a bit lasts 7 clk.
// Notes: Reports each byte as {bits, ack} on got_d with a got pulse.
module ccvr_host (
   input wire logic clk,
   input wire logic sda_oe,
   input wire logic sda_o,
   output logic scl,
   output wire logic sda,
   output logic got,
   output logic [8:0] got_d
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sda_h = 1'b1;
   // Open-drain wire: a released line reads high
   assign sda = sda_h & ~(sda_oe & ~sda_o);
   initial begin
      scl = 1'b1;
      got = 1'b0;
      got_d = 9'h000;
   end
   task automatic half;
      repeat (6) @(posedge clk);
   endtask
   task automatic bit_x(input logic b, output logic r);
      @(posedge clk) sda_h <= b;
      half;
      scl <= 1'b1;
      half;
      @(negedge clk) r = sda;
      @(posedge clk) scl <= 1'b0;
   endtask
   task automatic start;
      @(posedge clk) sda_h <= 1'b1;
      half;
      scl <= 1'b1;
      half;
      sda_h <= 1'b0;
      half;
      scl <= 1'b0;
   endtask
   task automatic stop;
      @(posedge clk) sda_h <= 1'b0;
      half;
      scl <= 1'b1;
      half;
      sda_h <= 1'b1;
      half;
   endtask
   task automatic byte_x(input logic [7:0] d, input logic ack_in);
      logic [8:0] r;
      for (int i = 8; i >= 0; i--) bit_x(i > 0 ? d[i-1] : ack_in, r[i]);
      got_d <= r;
      got <= 1'b1;
      @(posedge clk) got <= 1'b0;
   endtask
endmodule

/* File: sim/charge_current_voltage_regs_bench.sv */
// Purpose: Self-checking bench for the charge register bank.
// Assumes: Host model issues all bus traffic.
// Notes: Fast charge codes are kept at or below 0x27.
module charge_current_voltage_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, sda, sda_o, sda_oe, got;
   logic [8:0] got_d;
   logic [12:0] fc, cv;
   logic [11:0] pc, tc, ex;
   logic [8:0] ro;
   logic [6:0] ct;
   int failures = 0;
   int n_compared = 0;
   logic [8:0] exp_q[$];
   logic [31:0] rs = 32'h00012F4E;
   initial forever #10 clk = ~clk;
   ccvr_top uut (.clk, .nrst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
      .fast_charge_target_ma(fc), .precharge_target_ma(pc), .termination_target_ma(tc),
      .charge_voltage_target_mv(cv), .precharge_exit_mv(ex), .recharge_offset_mv(ro),
      .boost_cold_threshold_pct(ct));
   ccvr_host host (.clk, .sda_oe, .sda_o, .scl, .sda, .got, .got_d);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bx(input logic [7:0] d, input logic a, input logic [8:0] e);
      exp_q.push_back(e);
      host.byte_x(d, a);
   endtask
   task automatic bw(input logic [7:0] d);
      bx(d, 1'b1, {d, 1'b0});
   endtask
   task automatic br(input logic [7:0] v, input logic a);
      bx(8'hFF, a, {v, a});
   endtask
   task automatic wr(input logic [7:0] a, b, c);
      host.start;
      bw(8'hD6);
      bw(8'h02);
      bw(a);
      bw(b);
      bw(c);
      host.stop;
   endtask
   // Reads 0x02..0x05; the last offset is unmapped and ends with a NACK
   task automatic rd(input logic [7:0] a, b, c);
      host.start;
      bw(8'hD6);
      bw(8'h02);
      host.start;
      bw(8'hD7);
      br(a, 1'b0);
      br(b, 1'b0);
      br(c, 1'b0);
      br(8'h00, 1'b1);
      host.stop;
   endtask
   task automatic dec(input logic [7:0] a, b, c);
      logic [12:0] f, p;
      f = 13'h200 + a[7:2] * 13'h040;
      p = (b[7:4] < 4'h2) ? 13'h080 : (b[7:4] + 13'h001) * 13'h080;
      if (a[0]) begin
         f = f / 13'h005;
         p = p / 13'h002;
      end
      chk(fc, f);
      chk(13'(pc), p);
      chk(13'(tc), 13'h080 + b[2:0] * 13'h080);
      chk(cv, 13'hDB0 + c[7:2] * 13'h010);
      chk(13'(ex), c[1] ? 13'hBB8 : 13'hAF0);
      chk(13'(ro), c[0] ? 13'h12C : 13'h064);
      chk(13'(ct), a[1] ? 13'h04F : 13'h04C);
   endtask
   always @(posedge clk) begin
      if (got === 1'b1)
         chk(13'(got_d), 13'(exp_q.pop_front()));
   end
   initial begin
      logic [7:0] a, b, c;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         rd(8'h60, 8'h11, 8'hB2);
         dec(8'h60, 8'h11, 8'hB2);
         $display("Defaults test done");
         for (int i = 0; i < 6; i++) begin
            rs = lfsr(rs);
            a = {rs[5:0] % 6'd40, rs[6], i[0]};
            if (i == 0)
               a[7:2] = 6'h27;
            b = rs[15:8] & 8'hF7;
            c = rs[23:16];
            wr(a, b, c);
            rd(a, b, c);
            dec(a, b, c);
         end
         $display("Random write test done");
         // A foreign address must leave the registers untouched
         host.start;
         bx(8'hD4, 1'b1, 9'h1A9);
         bx(8'h02, 1'b1, 9'h005);
         bx(8'h00, 1'b1, 9'h001);
         host.stop;
         rd(a, b, c);
         $display("Foreign address test done");
         @(posedge clk) nrst <= 1'b0;
         repeat (3) @(posedge clk);
         nrst <= 1'b1;
      end
      give_verdict;
   end
   initial begin
      #1ms;
      failures++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict;
   end
endmodule
